// ### logic/iss_pkg.sv
// Constants for the interrupt shadow set selection block
package iss_pkg;

  localparam int          ISS_AW          = 16;
  localparam int          ISS_NVEC        = 15;
  localparam int          ISS_NLVL        = 3;

  // Priority shadow register: base and its clear/set/invert aliases
  localparam logic [15:0] ISS_PRIO_OFS    = 16'h0010;
  localparam logic [15:0] ISS_ALIAS_CLR   = 16'h0004;
  localparam logic [15:0] ISS_ALIAS_SET   = 16'h0008;
  localparam logic [15:0] ISS_ALIAS_INV   = 16'h000C;
  localparam logic [31:0] ISS_PRIO_MASK   = 32'h0000FFF1;
  localparam logic [31:0] ISS_PRIO_RST    = 32'h00000000;
  localparam int          ISS_SV_EN_BIT   = 0;
  localparam int          ISS_LVL1_LSB    = 4;
  localparam int          ISS_FIELD_W     = 4;

  // Vector displacement registers, entry i holds interrupt 107 + i
  localparam logic [31:0] ISS_VEC_MASK    = 32'h0003FFFE;
  localparam logic [31:0] ISS_VEC_RST     = 32'h00000000;
  localparam int          ISS_VEC_W       = 18;
  localparam logic [15:0] ISS_VEC_OFS [ISS_NVEC] = '{
    16'h06EC, 16'h06F0, 16'h0654, 16'h0658, 16'h06EC,
    16'h0700, 16'h0704, 16'h0708, 16'h0700, 16'h0710,
    16'h0714, 16'h0718, 16'h0710, 16'h0720, 16'h0724
  };

  // Shadow set used by the single vector when enabled
  localparam logic [2:0]  ISS_SV_SET      = 3'h1;
  localparam logic [2:0]  ISS_SET_DEFAULT = 3'h0;

endpackage : iss_pkg

// ### logic/iss_level_decode.sv
// Decode of one priority level's shadow set choice field
`timescale 1ns/1ps
module iss_level_decode
  import iss_pkg::*;
(
  input  wire logic [3:0] choice,
  output      logic [2:0] set_num
);

  // Reserved codes fall back to set 0 so a stray write cannot pick an odd set
  always_comb begin
    if (choice[3]) begin
      set_num = ISS_SET_DEFAULT;
    end else begin
      set_num = choice[2:0];
    end
  end

endmodule // iss_level_decode

// ### logic/iss_shadow_select.sv
// Shadow set selection and vector displacement registers
//
// Overview of operation
// - Level 3/2/1 choice fields at 15-12/11-8/7-4
// - Choice 0-7 selects that shadow set number
// - Reserved choice 1xxx falls back to set 0
// - Single-vector bit 0 enables shadow set use
// - Level fields ignored unless multi-vector mode
// - Aliases +4/+8/+C clear, set, invert bits
// - Displacement registers decode base address only
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module iss_shadow_select
  import iss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ISS_AW-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output      logic [31:0]       rdata,
  input  wire logic              multi_vector_mode,
  input  wire logic              take,
  input  wire logic [2:0]        take_level,
  input  wire logic [3:0]        take_vec,
  output      logic              sel_valid,
  output      logic              shadow_use,
  output      logic [2:0]        shadow_set,
  output      logic [17:0]       vec_offset
);

  logic [31:0] prio_r;
  logic [31:0] vec_r [ISS_NVEC];
  logic [2:0]  lvl_set [ISS_NLVL];
  logic [31:0] rd_nxt;
  logic        rd_hit;
  logic [2:0]  set_nxt;
  logic        use_nxt;
  logic        single_vector_shadow_en;

  assign single_vector_shadow_en = prio_r[ISS_SV_EN_BIT];

  // Priority register, written at base or through one of its aliases
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prio_r <= ISS_PRIO_RST;
    end else if (wr) begin
      if (addr == ISS_PRIO_OFS) begin
        prio_r <= wdata & ISS_PRIO_MASK;
      end else if (addr == ISS_PRIO_OFS + ISS_ALIAS_CLR) begin
        prio_r <= prio_r & ~wdata & ISS_PRIO_MASK;
      end else if (addr == ISS_PRIO_OFS + ISS_ALIAS_SET) begin
        prio_r <= (prio_r | wdata) & ISS_PRIO_MASK;
      end else if (addr == ISS_PRIO_OFS + ISS_ALIAS_INV) begin
        prio_r <= (prio_r ^ wdata) & ISS_PRIO_MASK;
      end
    end
  end

  // Displacement registers; entries sharing an address take the same write
  for (genvar i = 0; i < ISS_NVEC; i++) begin : g_vec
    always_ff @(posedge clk) begin
      if (!nrst) begin
        vec_r[i] <= ISS_VEC_RST;
      end else if (wr && addr == ISS_VEC_OFS[i]) begin
        vec_r[i] <= wdata & ISS_VEC_MASK;
      end
    end
  end

  // One decoder per level field
  for (genvar l = 0; l < ISS_NLVL; l++) begin : g_lvl
    iss_level_decode u_dec (
      .choice  (prio_r[ISS_LVL1_LSB + ISS_FIELD_W*l +: ISS_FIELD_W]),
      .set_num (lvl_set[l])
    );
  end

  // Read decode; a shared address returns the lowest entry
  always_comb begin
    rd_nxt = 32'h00000000;
    rd_hit = 1'b0;
    if (addr == ISS_PRIO_OFS) begin
      rd_nxt = prio_r;
      rd_hit = 1'b1;
    end
    for (int i = ISS_NVEC - 1; i >= 0; i--) begin
      if (addr == ISS_VEC_OFS[i]) begin
        rd_nxt = vec_r[i] & ISS_VEC_MASK;
        rd_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= rd_hit ? rd_nxt : 32'h00000000;
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // Set selection for the interrupt being taken
  always_comb begin
    set_nxt = ISS_SET_DEFAULT;
    use_nxt = 1'b0;
    if (multi_vector_mode) begin
      case (take_level)
        3'd1: begin
          set_nxt = lvl_set[0];
          use_nxt = 1'b1;
        end
        3'd2: begin
          set_nxt = lvl_set[1];
          use_nxt = 1'b1;
        end
        3'd3: begin
          set_nxt = lvl_set[2];
          use_nxt = 1'b1;
        end
        default: begin
          set_nxt = ISS_SET_DEFAULT;
          use_nxt = 1'b0;
        end
      endcase
    end else if (single_vector_shadow_en) begin
      set_nxt = ISS_SV_SET;
      use_nxt = 1'b1;
    end
  end

  // Outputs held until the next take so the core may sample late
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shadow_set <= ISS_SET_DEFAULT;
      shadow_use <= 1'b0;
      vec_offset <= 18'h00000;
    end else if (take) begin
      shadow_set <= set_nxt;
      shadow_use <= use_nxt;
      vec_offset <= (take_vec < 4'(ISS_NVEC)) ? vec_r[take_vec][ISS_VEC_W-1:0] : 18'h00000;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_valid <= 1'b0;
    end else begin
      sel_valid <= take;
    end
  end

  // Checks
  property p_prio_read;
    @(posedge clk) disable iff (!nrst)
      (rd && addr == ISS_PRIO_OFS) |=> (rdata == $past(prio_r));
  endproperty
  a_prio_read: assert property (p_prio_read) else $error("priority read data wrong");

  property p_unmapped;
    @(posedge clk) disable iff (!nrst)
      (rd && !rd_hit) |=> (rdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_clr;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_PRIO_OFS + ISS_ALIAS_CLR)
        |=> (prio_r == ($past(prio_r) & ~$past(wdata) & ISS_PRIO_MASK));
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias wrong");

  property p_set;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_PRIO_OFS + ISS_ALIAS_SET)
        |=> (prio_r == (($past(prio_r) | $past(wdata)) & ISS_PRIO_MASK));
  endproperty
  a_set: assert property (p_set) else $error("set alias wrong");

  property p_inv;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_PRIO_OFS + ISS_ALIAS_INV)
        |=> (prio_r == (($past(prio_r) ^ $past(wdata)) & ISS_PRIO_MASK));
  endproperty
  a_inv: assert property (p_inv) else $error("invert alias wrong");

  property p_vec_bits;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_VEC_OFS[2]) ##1 (rd && addr == ISS_VEC_OFS[2])
        |=> (rdata == ($past(wdata, 2) & ISS_VEC_MASK));
  endproperty
  a_vec_bits: assert property (p_vec_bits) else $error("displacement bits wrong");

  property p_map;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && take_level == 3'd3 && !prio_r[15])
        |=> (shadow_use && shadow_set == $past(prio_r[14:12]));
  endproperty
  a_map: assert property (p_map) else $error("level 3 set not taken");

  property p_reserved;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && take_level == 3'd1 && prio_r[7])
        |=> (shadow_set == 3'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved did not use set 0");

  property p_single;
    @(posedge clk) disable iff (!nrst)
      (take && !multi_vector_mode)
        |=> (shadow_use == $past(prio_r[0]));
  endproperty
  a_single: assert property (p_single) else $error("single vector shadow wrong");

  property p_rd_idle;
    @(posedge clk) disable iff (!nrst)
      !rd |=> (rdata == 32'h00000000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");

  property p_prio_write;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_PRIO_OFS) |=> (prio_r == ($past(wdata) & ISS_PRIO_MASK));
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write wrong");

  property p_prio_unimpl;
    @(posedge clk) disable iff (!nrst)
      (rd && addr == ISS_PRIO_OFS) |=> ((rdata & ~ISS_PRIO_MASK) == 32'h00000000);
  endproperty
  a_prio_unimpl: assert property (p_prio_unimpl) else $error("unused priority bits set");

  property p_vec_write;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_VEC_OFS[10]) |=> (vec_r[10] == ($past(wdata) & ISS_VEC_MASK));
  endproperty
  a_vec_write: assert property (p_vec_write) else $error("displacement write wrong");

  property p_vec_no_alias;
    @(posedge clk) disable iff (!nrst)
      (wr && addr == ISS_VEC_OFS[11] + ISS_ALIAS_CLR) |=> $stable(vec_r[11]);
  endproperty
  a_vec_no_alias: assert property (p_vec_no_alias) else $error("displacement alias decoded");

  property p_lvl2;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && take_level == 3'h2 && !prio_r[11])
        |=> (shadow_use && shadow_set == $past(prio_r[10:8]));
  endproperty
  a_lvl2: assert property (p_lvl2) else $error("level 2 set not taken");

  property p_lvl1;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && take_level == 3'h1 && !prio_r[7])
        |=> (shadow_use && shadow_set == $past(prio_r[6:4]));
  endproperty
  a_lvl1: assert property (p_lvl1) else $error("level 1 set not taken");

  property p_res3;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && take_level == 3'h3 && prio_r[15])
        |=> (shadow_use && shadow_set == 3'h0);
  endproperty
  a_res3: assert property (p_res3) else $error("level 3 reserved did not use set 0");

  property p_res2;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && take_level == 3'h2 && prio_r[11])
        |=> (shadow_use && shadow_set == 3'h0);
  endproperty
  a_res2: assert property (p_res2) else $error("level 2 reserved did not use set 0");

  property p_other_lvl;
    @(posedge clk) disable iff (!nrst)
      (take && multi_vector_mode && (take_level == 3'h0 || take_level > 3'h3))
        |=> (!shadow_use && shadow_set == 3'h0);
  endproperty
  a_other_lvl: assert property (p_other_lvl) else $error("unmapped level used a set");

  property p_single_set;
    @(posedge clk) disable iff (!nrst)
      (take && !multi_vector_mode && prio_r[0]) |=> (shadow_set == ISS_SV_SET);
  endproperty
  a_single_set: assert property (p_single_set) else $error("single vector set wrong");

  property p_single_off;
    @(posedge clk) disable iff (!nrst)
      (take && !multi_vector_mode && !prio_r[0]) |=> (!shadow_use && shadow_set == 3'h0);
  endproperty
  a_single_off: assert property (p_single_off) else $error("single vector set not off");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
      !take |=> ($stable(shadow_use) && $stable(shadow_set) && $stable(vec_offset));
  endproperty
  a_hold: assert property (p_hold) else $error("selection changed without take");

  property p_valid_pulse;
    @(posedge clk) disable iff (!nrst)
      take |=> sel_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid missing after take");

  property p_valid_low;
    @(posedge clk) disable iff (!nrst)
      !take |=> !sel_valid;
  endproperty
  a_valid_low: assert property (p_valid_low) else $error("valid without take");

  property p_vec_sel;
    @(posedge clk) disable iff (!nrst)
      (take && take_vec == 4'h2) |=> (vec_offset == $past(vec_r[2][ISS_VEC_W-1:0]));
  endproperty
  a_vec_sel: assert property (p_vec_sel) else $error("displacement not presented");

  property p_vec_none;
    @(posedge clk) disable iff (!nrst)
      (take && take_vec == 4'hF) |=> (vec_offset == 18'h00000);
  endproperty
  a_vec_none: assert property (p_vec_none) else $error("missing entry not zero");

endmodule // iss_shadow_select

// ### dv/iss_core_model.sv
// Core side model that takes interrupts and asks for a shadow set
`timescale 1ns/1ps
module iss_core_model
  import iss_pkg::*;
(
  input  wire logic       clk,
  output      logic       take,
  output      logic [2:0] take_level,
  output      logic [3:0] take_vec
);
  initial begin
    take       = 1'b0;
    take_level = 3'h0;
    take_vec   = 4'h0;
  end

  // One-cycle take; level and vector are driven inverted once released, while take stays low
  task automatic take_one(input logic [2:0] l, input logic [3:0] v);
    @(posedge clk);
    take       <= 1'b1;
    take_level <= l;
    take_vec   <= v;
    @(posedge clk);
    take       <= 1'b0;
    take_level <= ~l;
    take_vec   <= ~v;
  endtask
endmodule // iss_core_model

// ### dv/iss_shadow_select_tb.sv
// Register and shadow set selection tests
`timescale 1ns/1ps
module iss_shadow_select_tb;
  import iss_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        multi_vector_mode = 1'b0;
  logic [31:0] rdata;
  logic        take, sel_valid, shadow_use;
  logic [2:0]  take_level, shadow_set, lv;
  logic [3:0]  take_vec, c;
  logic [17:0] vec_offset;
  int          n_errors = 0;
  int          num_checks = 0;

  always #4 clk = ~clk;

  iss_shadow_select iss_shadow_select_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .multi_vector_mode(multi_vector_mode),
    .take(take), .take_level(take_level), .take_vec(take_vec), .sel_valid(sel_valid),
    .shadow_use(shadow_use), .shadow_set(shadow_set), .vec_offset(vec_offset));
  iss_core_model iss_core_model_inst (.clk(clk), .take(take), .take_level(take_level),
    .take_vec(take_vec));

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One strobe cycle; returns just after the edge where read data stands
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic tk(input logic [2:0] l, input logic [3:0] v, input logic u,
                    input logic [2:0] s, input logic [17:0] o);
    iss_core_model_inst.take_one(l, v);
    #1;
    chk({9'h0, sel_valid, shadow_use, shadow_set, vec_offset}, {9'h0, 1'b1, u, s, o});
  endtask

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdc(16'h0010, 32'h0);
    rdc(16'h0654, 32'h0);
    bus(1'b1, 16'h0010, 32'hFFFFFFFF);
    rdc(16'h0010, 32'h0000FFF1);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    bus(1'b1, 16'h0010, 32'h00003210);
    bus(1'b1, 16'h0014, 32'h00000010);
    bus(1'b1, 16'h0018, 32'h00000001);
    bus(1'b1, 16'h001C, 32'h0000F000);
    rdc(16'h0010, 32'h0000C201);
    // Write then read in the very next cycle must see the new value
    @(posedge clk);
    wr <= 1'b1;
    addr <= 16'h0654;
    wdata <= 32'hFFFFFFFF;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, 32'h0003FFFE);
    bus(1'b1, 16'h0714, 32'h00001234);
    bus(1'b1, 16'h0718, 32'h0000FFFE);
    bus(1'b1, 16'h071C, 32'h0000FFFF);
    rdc(16'h0714, 32'h00001234);
    rdc(16'h0718, 32'h0000FFFE);
    rdc(16'h071C, 32'h0);
    rdc(16'h0030, 32'h0);
    bus(1'b1, 16'h0010, 32'h00007A31);
    @(posedge clk);
    multi_vector_mode <= 1'b1;
    tk(3'd3, 4'd2, 1'b1, 3'd7, 18'h3FFFE);
    tk(3'd2, 4'd13, 1'b1, 3'd0, 18'h0);
    tk(3'd1, 4'd2, 1'b1, 3'd3, 18'h3FFFE);
    tk(3'd5, 4'd2, 1'b0, 3'd0, 18'h3FFFE);
    tk(3'd5, 4'd15, 1'b0, 3'd0, 18'h0);
    // Every choice code, on the three level fields in rotation
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      lv = 3'(i % 3 + 1);
      bus(1'b1, 16'h0010, 32'(c) << (4 * lv));
      tk(lv, 4'd0, 1'b1, c[3] ? 3'd0 : c[2:0], 18'h0);
    end
    bus(1'b1, 16'h0010, 32'h00007771);
    @(posedge clk);
    multi_vector_mode <= 1'b0;
    tk(3'd3, 4'd14, 1'b1, ISS_SV_SET, 18'h0);
    bus(1'b1, 16'h0014, 32'h00000001);
    tk(3'd3, 4'd14, 1'b0, 3'd0, 18'h0);
    complete_run();
  end
endmodule // iss_shadow_select_tb
